// *** rxf_top.sv ***
// Functional notes
// [R1] Each channel buffers receive data in two alternating 32-byte pools.
// [R2] Bit mode: pool-full event when 32 bytes readable and frame unfinished.
// [R3] Bit mode: message-end event when short frame or frame tail stored.
// [R4] At message end the frame length goes to length low/high registers.
// [R5] Address and control fields are latched and also kept in the buffer.
// [R6] Status byte is appended as the last byte of each frame.
// [R7] Character mode: pool-full event at the programmed threshold.
// [R8] Termination character ends the block and raises a termination event.
// [R9] Buffer-read command hands buffered data over and raises termination.
// [R10] Optionally keep parity bit, parity and framing error per character.
// [R11] After termination or buffer-read, block length goes to length low.
// [R12] Host issues message-complete after reading the buffered data.
// [R13] Unserviced pools and further data raise a receive overflow flag.
// [R14] DMA request for a full pool drops at start of last read cycle.
// [R15] DMA controller reads back to back while the request is high.
// [R16] Short blocks request exactly the needed byte or word cycles.
// [R17] After a block end, no DMA request until message-complete.
// [R18] Host sets up DMA before issuing message-complete.
// [R19] Status byte is delivered by the final DMA read of a frame.
// [R20] Eight channel blocks, 0x40 indices apart, decoded from the address.
// [R21] Global registers read the same through any channel's block.
// [R22] Host ignores unused addresses; they read zero and ignore writes.
// [R23] Any index in the 32-entry window reads the current receive data.
// [R24] DMA bit of the transmit length high register selects DMA mode.
// [R25] Message-complete frees the host's pool and its pending length.
`include "rxf_regs.svh"
`default_nettype none
module rxf_top
  import rxf_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [10:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Receiver byte stream
  input wire logic RX_VALID,
  input wire logic [2:0] RX_CHAN,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_END,
  input wire logic [7:0] RX_STATUS,
  input wire logic [2:0] RX_CHAR_FLAGS,
  // DMA requests and event summary
  output logic [7:0] RX_DMA_REQ,
  output logic EVENT_PENDING
);
  // ========================================================================
  // State.
  rxf_state_type s_reg;
  rxf_state_type s_next;
  logic [8:0] idx;
  logic [2:0] csel;
  logic [5:0] ofs;
  logic setup_rd;
  logic access;
  logic [7:0] global_event_status;

  assign idx = PADDR[`RXF_ADDR_IDX];
  assign csel = idx[`RXF_IDX_CH];
  assign ofs = idx[`RXF_IDX_OFS];
  assign setup_rd = PSEL && !PENABLE && !PWRITE;
  assign access = PSEL && PENABLE;
  assign PREADY = 1'b1;
  assign PSLVERR = 1'b0;
  assign PRDATA = s_reg.rdata;

  // ========================================================================
  // Block hand-over: the finished block becomes readable by host or DMA.
  function automatic rxf_ch_type give(input rxf_ch_type c,
                                      input logic [5:0] len,
                                      input logic endf,
                                      input logic term);
    rxf_ch_type r;
    r = c;
    r.hand_valid = 1'b1;
    r.hand_len = len;
    r.hand_end = endf;
    r.hand_term = term;
    if (!r.tx_length_high_dma_select[`RXF_TX_LENGTH_HIGH_DMA_SELECT_DMA]) begin
      if (!endf) begin
        r.flags_a[`RXF_EV_POOL] = 1'b1; // [R2] [R7]
      end else if (term) begin
        r.flags_a[`RXF_EV_TERM] = 1'b1; // [R8] [R9]
      end else begin
        r.flags_a[`RXF_EV_MSG_END] = 1'b1; // [R3]
      end
    end else if (endf && len == 6'h00) begin
      r.flags_a[term ? `RXF_EV_TERM : `RXF_EV_MSG_END] = 1'b1;
      r.dma_block = 1'b1; // [R17]
    end
    return r;
  endfunction

  // Closing the block in progress; a third block has no pool and overflows.
  function automatic rxf_ch_type close_blk(input rxf_ch_type c,
                                           input logic endf,
                                           input logic term);
    rxf_ch_type r;
    r = c;
    if (term) begin
      r.len_lo = {2'h0, c.fill}; // [R11]
    end
    if (!r.hand_valid) begin
      r = give(r, c.fill, endf, term); // [R1]
    end else if (!r.pend_valid) begin
      r.pend_valid = 1'b1;
      r.pend_len = c.fill;
      r.pend_end = endf;
      r.pend_term = term;
    end else begin
      r.flags_a[`RXF_EV_OVF] = 1'b1; // [R13]
      r.ovf_seen = 1'b1;
    end
    r.fill = 6'h00;
    return r;
  endfunction

  // Readable value of one channel's register at a given index.
  function automatic logic [31:0] rd_val(input rxf_ch_type c,
                                         input logic [5:0] o,
                                         input logic [7:0] g,
                                         input logic [7:0] v,
                                         input logic [7:0] p);
    logic [31:0] r;
    logic [5:0] nxt;
    r = 32'h0000_0000;
    nxt = c.rptr + 6'h01;
    if (!o[`RXF_OFS_WIN_BIT]) begin
      if (c.cfg4[`RXF_CFG4_WORD]) begin
        r = {16'h0000, c.mem[nxt][7:0], c.mem[c.rptr][7:0]}; // [R23]
      end else begin
        r = {21'h000000, c.mem[c.rptr]}; // [R23] [R10]
      end
    end else begin
      case (o)
        `RXF_OFS_STATE: r = {28'h0000000, c.ovf_seen, c.dma_block,
                             c.pend_valid, c.hand_valid};
        `RXF_OFS_FRAME_RECEIVE_STATUS: r = {24'h000000, c.frame_receive_status};
        `RXF_OFS_RFC: r = {24'h000000, c.rx_buffer_config};
        `RXF_OFS_TCR: r = {24'h000000, c.termination_value};
        `RXF_OFS_ADDR: r = {24'h000000, c.addr_field}; // [R5]
        `RXF_OFS_CTRL: r = {24'h000000, c.ctrl_field}; // [R5]
        `RXF_OFS_LENL: r = {24'h000000, c.len_lo};
        `RXF_OFS_LENH: r = {24'h000000, c.len_hi};
        `RXF_OFS_GIS: r = {16'h0000, v, g}; // [R21]
        `RXF_OFS_IPC: r = {24'h000000, p}; // [R21]
        `RXF_OFS_FLA: r = {24'h000000, c.flags_a};
        `RXF_OFS_FLB: r = {24'h000000, c.flags_b};
        `RXF_OFS_CFG4: r = {24'h000000, c.cfg4};
        default: r = 32'h0000_0000; // [R22]
      endcase
    end
    return r;
  endfunction

  // ========================================================================
  // Global event summary and DMA requests.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_chan
      logic [5:0] cycles;
      logic last_start;
      assign global_event_status[gi] = |(s_reg.ch[gi].flags_a & ~s_reg.ch[gi].mask_a);
      assign cycles = s_reg.ch[gi].cfg4[`RXF_CFG4_WORD] ?
                      6'((s_reg.ch[gi].hand_len + 6'h01) >> 1) :
                      s_reg.ch[gi].hand_len; // [R16]
      // The request stays low through setup and access of the last read.
      assign last_start = PSEL && !PWRITE &&
                          csel == 3'(gi) && !ofs[`RXF_OFS_WIN_BIT] &&
                          cycles == 6'h01; // [R14]
      assign RX_DMA_REQ[gi] = s_reg.ch[gi].tx_length_high_dma_select[`RXF_TX_LENGTH_HIGH_DMA_SELECT_DMA] && // [R24]
                              s_reg.ch[gi].hand_valid &&
                              !s_reg.ch[gi].dma_block && // [R17]
                              cycles != 6'h00 && !last_start; // [R14]
    end
  endgenerate
  assign EVENT_PENDING = |global_event_status;

  // ========================================================================
  // Next-state logic.
  always_comb begin
    rxf_ch_type ch;
    logic sel;
    logic [5:0] n;
    logic [5:0] thr;
    ch = s_reg.ch[0];
    sel = 1'b0;
    n = 6'h00;
    thr = `RXF_POOL_BYTES;
    s_next = s_reg;
    if (access && PWRITE) begin
      case (ofs)
        `RXF_OFS_GIS: s_next.vec = PWDATA[7:0]; // [R21]
        `RXF_OFS_IPC: s_next.event_port_config = PWDATA[7:0]; // [R21]
        default: s_next.vec = s_reg.vec;
      endcase
    end
    for (int c = 0; c < 8; c++) begin
      ch = s_reg.ch[c];
      sel = csel == 3'(c); // [R20]
      if (setup_rd && sel) begin
        s_next.rdata = rd_val(ch, ofs, global_event_status, s_reg.vec, s_reg.event_port_config);
      end
      // Software writes.
      if (access && PWRITE && sel) begin
        case (ofs)
          `RXF_OFS_STATE: begin
            if (PWDATA[`RXF_CMD_RMC]) begin
              ch.rptr = ch.rptr + ch.hand_len; // [R25]
              ch.cnt = ch.cnt - {1'b0, ch.hand_len};
              ch.hand_len = 6'h00;
              ch.hand_valid = 1'b0;
              ch.dma_block = 1'b0; // [R17]
            end
            if (PWDATA[`RXF_CMD_BUFFER_READ_CMD] && ch.cfg4[`RXF_CFG4_CHAR]) begin
              ch = close_blk(ch, 1'b1, 1'b1); // [R9]
            end
          end
          `RXF_OFS_RFC: ch.rx_buffer_config = PWDATA[7:0];
          `RXF_OFS_TCR: ch.termination_value = PWDATA[7:0];
          `RXF_OFS_LENH: ch.tx_length_high_dma_select = PWDATA[7:0]; // [R24]
          `RXF_OFS_FLA: ch.mask_a = PWDATA[7:0];
          `RXF_OFS_FLB: ch.mask_b = PWDATA[7:0];
          `RXF_OFS_CFG4: ch.cfg4 = PWDATA[7:0];
          default: ch.termination_value = ch.termination_value; // [R22]
        endcase
      end
      // A flag read clears only the bits that it returned; sets still win.
      if (access && !PWRITE && sel && ofs == `RXF_OFS_FLA) begin
        ch.flags_a = ch.flags_a & ~s_reg.rdata[7:0];
      end
      // Window reads consume one byte or one word of the handed block.
      if (access && !PWRITE && sel && !ofs[`RXF_OFS_WIN_BIT] &&
          ch.hand_len != 6'h00) begin
        n = (ch.cfg4[`RXF_CFG4_WORD] && ch.hand_len > 6'h01) ? 6'h02 : 6'h01;
        ch.rptr = ch.rptr + n;
        ch.cnt = ch.cnt - {1'b0, n};
        ch.hand_len = ch.hand_len - n;
        if (ch.tx_length_high_dma_select[`RXF_TX_LENGTH_HIGH_DMA_SELECT_DMA] && ch.hand_len == 6'h00) begin
          if (!ch.hand_end) begin
            ch.hand_valid = 1'b0;
          end else begin
            ch.dma_block = 1'b1; // [R17] [R19]
            ch.flags_a[ch.hand_term ? `RXF_EV_TERM : `RXF_EV_MSG_END] = 1'b1;
          end
        end
      end
      // Incoming bytes.
      if (RX_VALID && RX_CHAN == 3'(c)) begin
        case (ch.rx_buffer_config[`RXF_RFC_THR])
          2'h1: thr = `RXF_THR_16;
          2'h2: thr = `RXF_THR_4;
          2'h3: thr = `RXF_THR_2;
          default: thr = `RXF_POOL_BYTES;
        endcase
        if (ch.cnt == `RXF_BUF_BYTES) begin
          ch.flags_a[`RXF_EV_OVF] = 1'b1; // [R13]
          ch.ovf_seen = 1'b1;
        end else begin
          ch.mem[ch.wptr] = {RX_CHAR_FLAGS & {3{ch.cfg4[`RXF_CFG4_CHAR] &&
                             ch.rx_buffer_config[`RXF_RFC_STAT]}}, RX_DATA}; // [R10]
          ch.wptr = ch.wptr + 6'h01;
          ch.cnt = ch.cnt + 7'h01;
          ch.fill = ch.fill + 6'h01;
          if (!ch.cfg4[`RXF_CFG4_CHAR]) begin
            if (RX_END) begin
              ch.frame_receive_status = RX_STATUS; // [R6]
              ch.frame_receive_status[`RXF_FRAME_RECEIVE_STATUS_OVF] = RX_STATUS[`RXF_FRAME_RECEIVE_STATUS_OVF] ||
                                       ch.ovf_seen;
              ch.len_lo = ch.frame_cnt[7:0]; // [R4]
              ch.len_hi = {4'h0, ch.frame_cnt[11:8]}; // [R4]
              ch.frame_cnt = 12'h000;
              ch.ovf_seen = 1'b0;
              ch = close_blk(ch, 1'b1, 1'b0); // [R3]
            end else begin
              if (ch.frame_cnt == 12'h000) begin
                ch.addr_field = RX_DATA; // [R5]
              end
              if (ch.frame_cnt == 12'h001) begin
                ch.ctrl_field = RX_DATA; // [R5]
              end
              ch.frame_cnt = ch.frame_cnt + 12'h001;
              if (ch.fill == `RXF_POOL_BYTES) begin
                ch = close_blk(ch, 1'b0, 1'b0); // [R2]
              end
            end
          end else if (ch.rx_buffer_config[`RXF_RFC_TERM_DETECT_ENABLE] && RX_DATA == ch.termination_value) begin
            ch = close_blk(ch, 1'b1, 1'b1); // [R8]
          end else if (ch.fill == thr) begin
            ch = close_blk(ch, 1'b0, 1'b0); // [R7]
          end
        end
      end
      // The second pool moves up once the first is released.
      if (!ch.hand_valid && ch.pend_valid) begin
        ch = give(ch, ch.pend_len, ch.pend_end, ch.pend_term); // [R1]
        ch.pend_valid = 1'b0;
      end
      s_next.ch[c] = ch;
    end
  end

  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // ========================================================================
  // Checks on channel 0.
  logic rmc_hit0;
  assign rmc_hit0 = PSEL && PENABLE && PWRITE && PADDR[10:8] == 3'h0 &&
                    PADDR[7:2] == `RXF_OFS_STATE && PWDATA[`RXF_CMD_RMC];

  sequence win_rd0;
    PSEL && !PENABLE && !PWRITE && PADDR[10:8] == 3'h0 && !PADDR[7];
  endsequence
  sequence rmc0;
    rmc_hit0;
  endsequence
  sequence rx0;
    RX_VALID && RX_CHAN == 3'h0;
  endsequence

  dma_mode_sel_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R24]
    !s_reg.ch[0].tx_length_high_dma_select[`RXF_TX_LENGTH_HIGH_DMA_SELECT_DMA] |-> !RX_DMA_REQ[0])
    else $error("DMA request raised in interrupt mode");
  dma_block_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R17]
    s_reg.ch[0].dma_block && !rmc_hit0 |=> !RX_DMA_REQ[0])
    else $error("DMA request raised before message-complete");
  last_read_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R14]
    win_rd0 ##0 s_reg.ch[0].tx_length_high_dma_select[`RXF_TX_LENGTH_HIGH_DMA_SELECT_DMA] &&
    g_chan[0].cycles == 6'h01 |-> !RX_DMA_REQ[0] ##1 !RX_DMA_REQ[0])
    else $error("DMA request stood during the last read");
  window_data_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R23]
    win_rd0 ##0 !s_reg.ch[0].cfg4[`RXF_CFG4_WORD] |=>
    PRDATA[7:0] == $past(s_reg.ch[0].mem[s_reg.ch[0].rptr][7:0]))
    else $error("Window read did not return the current byte");
  overflow_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R13]
    rx0 ##0 s_reg.ch[0].cnt == `RXF_BUF_BYTES |=>
    s_reg.ch[0].flags_a[`RXF_EV_OVF])
    else $error("Overflow not flagged on a full buffer");
  pool_full_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R2]
    rx0 ##0 !RX_END && s_reg.ch[0].fill == 6'h1F &&
    s_reg.ch[0].cnt != `RXF_BUF_BYTES && !s_reg.ch[0].hand_valid &&
    s_reg.ch[0].cfg4 == 8'h00 && !s_reg.ch[0].tx_length_high_dma_select[`RXF_TX_LENGTH_HIGH_DMA_SELECT_DMA] |=>
    s_reg.ch[0].flags_a[`RXF_EV_POOL] && s_reg.ch[0].hand_len == 6'h20)
    else $error("Pool-full not raised at 32 bytes");
  frame_len_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R4]
    rx0 ##0 RX_END && !s_reg.ch[0].cfg4[`RXF_CFG4_CHAR] &&
    s_reg.ch[0].cnt != `RXF_BUF_BYTES |=>
    s_reg.ch[0].len_lo == $past(s_reg.ch[0].frame_cnt[7:0]) &&
    s_reg.ch[0].frame_cnt == 12'h000)
    else $error("Frame length not recorded at message end");
  term_char_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R8]
    rx0 ##0 s_reg.ch[0].cfg4[`RXF_CFG4_CHAR] &&
    s_reg.ch[0].rx_buffer_config[`RXF_RFC_TERM_DETECT_ENABLE] && RX_DATA == s_reg.ch[0].termination_value &&
    s_reg.ch[0].cnt != `RXF_BUF_BYTES |=> s_reg.ch[0].fill == 6'h00)
    else $error("Termination character did not end the block");
  rmc_free_a: assert property (@(posedge CLOCK) disable iff (!RSTN) // [R25]
    rmc0 ##0 !s_reg.ch[0].pend_valid && !RX_VALID |=>
    !s_reg.ch[0].hand_valid && s_reg.ch[0].hand_len == 6'h00)
    else $error("Message-complete did not free the pool");
endmodule
`default_nettype wire

// *** rxf_regs.svh ***
`ifndef RXF_REGS_SVH
`define RXF_REGS_SVH
// ==========================================================================
// Address fields: the byte address is four times the register index.
`define RXF_ADDR_IDX 10:2
`define RXF_IDX_CH 8:6
`define RXF_IDX_OFS 5:0
`define RXF_OFS_WIN_BIT 5
// ==========================================================================
// Channel-relative register indices.
`define RXF_OFS_STATE 6'h20
`define RXF_OFS_FRAME_RECEIVE_STATUS 6'h21
`define RXF_OFS_RFC 6'h26
`define RXF_OFS_TCR 6'h27
`define RXF_OFS_ADDR 6'h28
`define RXF_OFS_CTRL 6'h29
`define RXF_OFS_LENL 6'h2A
`define RXF_OFS_LENH 6'h2B
`define RXF_OFS_GIS 6'h38
`define RXF_OFS_IPC 6'h39
`define RXF_OFS_FLA 6'h3A
`define RXF_OFS_FLB 6'h3B
`define RXF_OFS_CFG4 6'h3F
// ==========================================================================
// Bit positions.
`define RXF_CMD_RMC 7
`define RXF_CMD_BUFFER_READ_CMD 5
`define RXF_TX_LENGTH_HIGH_DMA_SELECT_DMA 7
`define RXF_EV_MSG_END 7
`define RXF_EV_POOL 6
`define RXF_EV_TERM 5
`define RXF_EV_OVF 4
`define RXF_CFG4_CHAR 0
`define RXF_CFG4_WORD 1
`define RXF_RFC_THR 1:0
`define RXF_RFC_TERM_DETECT_ENABLE 2
`define RXF_RFC_STAT 3
`define RXF_FRAME_RECEIVE_STATUS_OVF 7
// ==========================================================================
// Sizes and thresholds.
`define RXF_POOL_BYTES 6'h20
`define RXF_BUF_BYTES 7'h40
`define RXF_THR_16 6'h10
`define RXF_THR_4 6'h04
`define RXF_THR_2 6'h02
`endif

// *** rxf_pkg.sv ***
`default_nettype none
package rxf_pkg;
  typedef struct packed {
    logic [63:0][10:0] mem;
    logic [5:0] wptr;
    logic [5:0] rptr;
    logic [6:0] cnt;
    logic [5:0] fill;
    logic [5:0] hand_len;
    logic hand_valid;
    logic hand_end;
    logic hand_term;
    logic [5:0] pend_len;
    logic pend_valid;
    logic pend_end;
    logic pend_term;
    logic dma_block;
    logic ovf_seen;
    logic [11:0] frame_cnt;
    logic [7:0] addr_field;
    logic [7:0] ctrl_field;
    logic [7:0] frame_receive_status;
    logic [7:0] len_lo;
    logic [7:0] len_hi;
    logic [7:0] flags_a;
    logic [7:0] mask_a;
    logic [7:0] flags_b;
    logic [7:0] mask_b;
    logic [7:0] cfg4;
    logic [7:0] tx_length_high_dma_select;
    logic [7:0] rx_buffer_config;
    logic [7:0] termination_value;
  } rxf_ch_type;

  typedef struct packed {
    rxf_ch_type [7:0] ch;
    logic [31:0] rdata;
    logic [7:0] vec;
    logic [7:0] event_port_config;
  } rxf_state_type;
endpackage
`default_nettype wire

// *** rxf_dma_model.sv ***
`default_nettype none
// ==========================================================================
// DMA controller: reads the receive window while the request stands.
module rxf_dma_model
  import rxf_pkg::*;
(
  // Clock, reset and control
  input wire logic clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic [2:0] chan,
  // Request and bus
  input wire logic [7:0] req,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic [10:0] paddr,
  // Progress
  output logic [15:0] n_reads,
  output logic [31:0] last_data
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= '0;
      n_reads <= '0;
      last_data <= '0;
    end else if (psel && !penable) begin
      penable <= 1'b1;
    end else if (psel && pready) begin
      // A new setup follows at once while the request is still high.
      n_reads <= n_reads + 16'h0001;
      last_data <= prdata;
      penable <= 1'b0;
      psel <= go && req[chan];
      paddr <= {chan, 1'b0, n_reads[4:0] + 5'h01, 2'b00};
    end else begin
      psel <= go && req[chan];
      paddr <= {chan, 1'b0, n_reads[4:0], 2'b00};
    end
  end
endmodule
`default_nettype wire

// *** rxf_tb_top.sv ***
`include "rxf_regs.svh"
`default_nettype none
`define CHK(g, e) begin \
  n_compared++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
  end \
end
module tb_top
  import rxf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ========================================================================
  // Signals
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic t_psel = 1'b0;
  logic t_pen = 1'b0;
  logic t_pwrite = 1'b0;
  logic [10:0] t_paddr = '0;
  logic [31:0] t_pwdata = '0;
  logic dma_go = 1'b0;
  logic [2:0] dma_ch = '0;
  logic d_psel, d_pen, pready, pslverr, ev_pend;
  logic [10:0] d_paddr;
  logic [15:0] dma_n;
  logic [31:0] dma_last, prdata, rd;
  logic [7:0] dma_req, r, st;
  logic rx_valid = 1'b0;
  logic rx_end = 1'b0;
  logic [2:0] rx_chan = '0;
  logic [2:0] rx_flags = '0;
  logic [7:0] rx_data = '0;
  logic [7:0] rx_stat = '0;
  logic [15:0] lfsr = 16'h0003;
  logic [10:0] q[$];
  logic [2:0] c;
  int n;
  int miscompares = 0;
  int n_compared = 0;

  always #50 clk = ~clk;

  rxf_top uut (
    .CLOCK(clk), .RSTN(rstn), .PSEL(t_psel | d_psel),
    .PENABLE(d_psel ? d_pen : t_pen), .PWRITE(t_pwrite & ~d_psel),
    .PADDR(d_psel ? d_paddr : t_paddr), .PWDATA(t_pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_VALID(rx_valid), .RX_CHAN(rx_chan), .RX_DATA(rx_data),
    .RX_END(rx_end), .RX_STATUS(rx_stat), .RX_CHAR_FLAGS(rx_flags),
    .RX_DMA_REQ(dma_req), .EVENT_PENDING(ev_pend));

  rxf_dma_model dma (
    .clk(clk), .rstn(rstn), .go(dma_go), .chan(dma_ch), .req(dma_req),
    .pready(pready), .prdata(prdata), .psel(d_psel), .penable(d_pen),
    .paddr(d_paddr), .n_reads(dma_n), .last_data(dma_last));

  // ========================================================================
  // Helpers
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction

  task automatic summarize();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [2:0] ch,
                     input logic [5:0] idx, input logic [7:0] d);
    t_psel <= 1'b1;
    t_pwrite <= w;
    t_paddr <= {ch, idx, 2'b00};
    t_pwdata <= {24'h000000, d};
    @(posedge clk);
    t_pen <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
      if (i == 19) begin
        miscompares++;
        summarize();
      end
    end
    rd = prdata;
    `CHK(pslverr, 1'b0)
    t_psel <= 1'b0;
    t_pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic put(input logic [7:0] b, input logic e);
    rx_valid <= 1'b1;
    rx_chan <= c;
    rx_data <= b;
    rx_end <= e;
    rx_stat <= b;
    rx_flags <= lfsr[10:8];
    q.push_back({lfsr[10:8], b});
    @(posedge clk);
  endtask

  task automatic send(input int k, input logic e);
    for (int i = 0; i < k; i++) put(rnd() & 8'h7F, 1'b0);
    if (e) put(st, 1'b1);
    rx_valid <= 1'b0;
    rx_end <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic drain(input int k, input logic [10:0] m);
    logic [10:0] e;
    for (int i = 0; i < k; i++) begin
      e = q.pop_front();
      r = rnd();
      apb(1'b0, c, {1'b0, r[4:0]}, 8'h00);
      `CHK(rd[10:0] & m, e & m)
    end
  endtask

  task automatic rdreg(input logic [5:0] idx);
    apb(1'b0, c, idx, 8'h00);
  endtask

  task automatic wait_dma(input int t);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      if (dma_n == 16'(t)) break;
      if (i == 399) begin
        miscompares++;
        summarize();
      end
    end
    repeat (8) @(posedge clk);
    `CHK(dma_n, 16'(t))
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    r = rnd();
    // Channel 0 carries the design's own checks.
    c = 3'h0;
    rdreg(`RXF_OFS_STATE);
    `CHK(rd[7:0], 8'h00)
    apb(1'b1, c, 6'h22, 8'h00);
    rdreg(6'h22);
    `CHK(rd, 32'h00000000)
    apb(1'b1, c, `RXF_OFS_IPC, 8'h5A);
    apb(1'b0, r[2:0] | 3'h1, `RXF_OFS_IPC, 8'h00);
    `CHK(rd[7:0], 8'h5A)
    // Short bit-mode frame in interrupt mode.
    r = rnd();
    n = 4 + r % 20;
    st = rnd() & 8'h7F;
    send(n, 1'b1);
    `CHK(ev_pend, 1'b1)
    rdreg(`RXF_OFS_FLA);
    `CHK(rd[7:4], 4'h8)
    rdreg(`RXF_OFS_FLA);
    `CHK(rd[7:4], 4'h0)
    rdreg(`RXF_OFS_LENL);
    `CHK(rd[7:0], 8'(n))
    rdreg(`RXF_OFS_LENH);
    `CHK(rd[3:0], 4'h0)
    rdreg(`RXF_OFS_FRAME_RECEIVE_STATUS);
    `CHK(rd[7:0], st)
    rdreg(`RXF_OFS_ADDR);
    `CHK(rd[7:0], q[0][7:0])
    rdreg(`RXF_OFS_CTRL);
    `CHK(rd[7:0], q[1][7:0])
    apb(1'b0, c ^ 3'h1, `RXF_OFS_LENL, 8'h00);
    `CHK(rd[7:0], 8'h00)
    drain(n + 1, 11'h0FF);
    apb(1'b1, c, `RXF_OFS_STATE, 8'h80);
    rdreg(`RXF_OFS_STATE);
    `CHK(rd[3:0], 4'h0)
    // Long frame spanning both pools.
    send(40, 1'b1);
    rdreg(`RXF_OFS_FLA);
    `CHK(rd[6], 1'b1)
    drain(32, 11'h0FF);
    apb(1'b1, c, `RXF_OFS_STATE, 8'h80);
    rdreg(`RXF_OFS_FLA);
    `CHK(rd[7], 1'b1)
    rdreg(`RXF_OFS_LENL);
    `CHK(rd[7:0], 8'h28)
    drain(9, 11'h0FF);
    apb(1'b1, c, `RXF_OFS_STATE, 8'h80);
    // Character mode: threshold, termination, buffer-read command.
    apb(1'b1, c, `RXF_OFS_CFG4, 8'h01);
    apb(1'b1, c, `RXF_OFS_RFC, 8'h01);
    send(16, 1'b0);
    rdreg(`RXF_OFS_FLA);
    `CHK(rd[6], 1'b1)
    drain(16, 11'h0FF);
    apb(1'b1, c, `RXF_OFS_STATE, 8'h80);
    apb(1'b1, c, `RXF_OFS_RFC, 8'h0C);
    apb(1'b1, c, `RXF_OFS_TCR, 8'hFF);
    send(3, 1'b0);
    put(8'hFF, 1'b0);
    send(0, 1'b0);
    rdreg(`RXF_OFS_FLA);
    `CHK(rd[5], 1'b1)
    rdreg(`RXF_OFS_LENL);
    `CHK(rd[7:0], 8'h04)
    drain(4, 11'h7FF);
    apb(1'b1, c, `RXF_OFS_STATE, 8'h80);
    send(5, 1'b0);
    apb(1'b1, c, `RXF_OFS_STATE, 8'h20);
    rdreg(`RXF_OFS_FLA);
    `CHK(rd[5], 1'b1)
    rdreg(`RXF_OFS_LENL);
    `CHK(rd[7:0], 8'h05)
    drain(5, 11'h7FF);
    apb(1'b1, c, `RXF_OFS_STATE, 8'h80);
    // DMA mode: full pool in words, short frame in bytes, blocking.
    apb(1'b1, c, `RXF_OFS_CFG4, 8'h02);
    apb(1'b1, c, `RXF_OFS_LENH, 8'h80);
    dma_ch <= c;
    dma_go <= 1'b1;
    send(32, 1'b0);
    wait_dma(16);
    apb(1'b1, c, `RXF_OFS_CFG4, 8'h00);
    st = rnd() & 8'h7F;
    send(5, 1'b1);
    wait_dma(22);
    `CHK(dma_last[7:0], st)
    rdreg(`RXF_OFS_FLA);
    `CHK(rd[7], 1'b1)
    send(3, 1'b1);
    repeat (10) @(posedge clk);
    `CHK(dma_req[c], 1'b0)
    apb(1'b1, c, `RXF_OFS_STATE, 8'h80);
    wait_dma(26);
    dma_go <= 1'b0;
    rdreg(`RXF_OFS_FLA);
    `CHK(rd[7], 1'b1)
    // Overflow on an unserviced pool pair, with the event masked.
    apb(1'b1, c, `RXF_OFS_LENH, 8'h00);
    apb(1'b1, c, `RXF_OFS_STATE, 8'h80);
    q.delete();
    send(65, 1'b0);
    apb(1'b1, c, `RXF_OFS_FLA, 8'hFF);
    `CHK(ev_pend, 1'b0)
    rdreg(`RXF_OFS_FLA);
    `CHK(rd[4], 1'b1)
    rdreg(`RXF_OFS_STATE);
    `CHK(rd[3], 1'b1)
    summarize();
  end
endmodule
`default_nettype wire
